// ---- tcd_decoder.sv ----
// Contract
// - Four step bits form a binary index, bit three most significant.
// - Preset at full scale equals maximum frequency.
// - Two ramp bits select one of four ramp time pairs.
// - Motor select bits choose motor set one or two.
// - Every input has a software filter, default ten milliseconds.
// - Command mode 0..3 selects two- or three-wire variant, default 0.
// - Two-wire 1: forward level on terminal one, reverse on two.
// - Two-wire 2: terminal one enables run, terminal two picks direction.
// - Three-wire 1: with terminal three closed, rising edges start runs.
// - Three-wire 1: opening terminal three stops the motor.
// - Three-wire 1: direction inputs edge-triggered, terminal three level.
// - Function 39 replaces primary source with preset frequency.
// - Function 40 replaces auxiliary source with preset frequency.
// - With terminal PID switching, function 43 selects gain set two.
// - User faults one and two raise their codes and fault action; when both rise in one cycle only the fault one code is raised.
// - Function 46 swaps configured speed or torque mode.
// - Emergency terminal requests fastest current-limited stop.
// - Function 48 stops in any command source with ramp set four.
// - DC brake terminal decelerates then enters DC braking.
// - Function 50 clears the current run-time counter.
//
// Purpose: Decodes filtered digital terminals into drive commands.
// Assumes: Configuration ports are static or change between runs.
// Notes:   Step presets are 0.1 percent of maximum frequency; frequencies are 16-bit.
`timescale 1ns/1ps
`default_nettype none
`include "tcd_regs.svh"
module tcd_decoder
   import tcd_pkg::*;
(
   input  wire logic                         clk_in,        // Clock 125 MHz
   input  wire logic                         rst_in,        // Synchronous reset
   input  wire logic                         ce_in,         // Clock enable
   input  wire logic [`TCD_NUM_TERM-1:0]     terminal_in,   // Raw terminals
   input  wire logic [`TCD_NUM_TERM*6-1:0]   term_fn_in,    // Function per terminal
   input  wire logic [9:0]                   input_filter_time_in, // Filter ms
   input  wire logic [1:0]                   terminal_command_mode_in, // Mode
   input  wire logic                         cmd_source_terminal_in, // Terminals own run
   input  wire logic [1:0]                   pid_gain_switch_condition_in, // PID cond
   input  wire logic                         speed_torque_mode_select_in, // 1 torque
   input  wire logic [15:0]                  max_frequency_in, // Maximum frequency
   input  wire logic [15:0]                  preset_frequency_in, // Preset freq
   input  wire logic [15:0]                  main_source_in, // Primary source
   input  wire logic [15:0]                  aux_source_in, // Auxiliary source
   input  wire logic [16*16-1:0]             step_presets_in, // Presets 0.1 percent
   output tcd_cmd_s                          cmd_out,       // Run commands
   output tcd_sel_s                          sel_out,       // Selections
   output logic [15:0]                       step_freq_out, // Scaled preset
   output logic [15:0]                       main_freq_out, // Primary after switch
   output logic [15:0]                       aux_freq_out,  // Auxiliary after switch
   output logic                              fault_out,     // User fault pulse
   output logic [7:0]                        fault_code_out, // Fault code
   output logic [`TCD_NUM_TERM-1:0]          filtered_out   // Filtered levels
);
   localparam int TICK_W = 18;
   logic [TICK_W-1:0]         tick_cnt_r;
   wire                       tick = (tick_cnt_r == TICK_W'(`TCD_TICK_CYCLES - 1));
   logic [`TCD_NUM_TERM-1:0]  lvl;
   logic [63:0]               fn_act;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         tick_cnt_r <= '0;
      end else if (ce_in) begin
         tick_cnt_r <= tick ? '0 : tick_cnt_r + TICK_W'(1);
      end
   end

   genvar g;
   generate
      for (g = 0; g < `TCD_NUM_TERM; g++) begin : g_term
         tcd_filter u_filt (
            .clk_in     (clk_in),
            .rst_in     (rst_in),
            .ce_in      (ce_in),
            .tick_in    (tick),
            .filt_ms_in (input_filter_time_in),
            .pin_in     (terminal_in[g]),
            .level_out  (lvl[g])
         );
      end
      for (g = 0; g < 64; g++) begin : g_fn
         logic [`TCD_NUM_TERM-1:0] hit;
         for (genvar t = 0; t < `TCD_NUM_TERM; t++) begin : g_t
            assign hit[t] = lvl[t] && (term_fn_in[t*6 +: 6] == 6'(g));
         end
         assign fn_act[g] = |hit;
      end
   endgenerate
   assign filtered_out = lvl;

   wire f_fwd  = fn_act[`TCD_FN_FWD];
   wire f_rev  = fn_act[`TCD_FN_REV];
   wire f_3w   = fn_act[`TCD_FN_3WIRE];
   wire [3:0] step_idx = {fn_act[`TCD_FN_STEP3], fn_act[`TCD_FN_STEP2],
                          fn_act[`TCD_FN_STEP1], fn_act[`TCD_FN_STEP0]};
   wire [1:0] ramp_sel = {fn_act[`TCD_FN_RAMP1], fn_act[`TCD_FN_RAMP0]};
   wire f_estop = fn_act[`TCD_FN_ESTOP];
   wire f_fstop = fn_act[`TCD_FN_FSTOP];
   wire f_uf1   = fn_act[`TCD_FN_UFAULT1];
   wire f_uf2   = fn_act[`TCD_FN_UFAULT2];
   tcd_mode_e mode;
   assign mode = tcd_mode_e'(terminal_command_mode_in);

   logic fwd_d_r;
   logic rev_d_r;
   logic uf1_d_r;
   logic uf2_d_r;
   tcd_run_e run3_r;
   tcd_run_e run_nxt;
   wire fwd_rise = f_fwd && !fwd_d_r;
   wire rev_rise = f_rev && !rev_d_r;

   always_comb begin
      run_nxt = TCD_STOPPED;
      case (mode)
         TCD_TWO_WIRE_1: begin
            if (f_fwd && !f_rev) run_nxt = TCD_RUN_FWD;
            else if (f_rev && !f_fwd) run_nxt = TCD_RUN_REV;
         end
         TCD_TWO_WIRE_2: begin
            if (f_fwd) run_nxt = f_rev ? TCD_RUN_REV : TCD_RUN_FWD;
         end
         TCD_THREE_WIRE_1: begin
            if (!f_3w) run_nxt = TCD_STOPPED;
            else if (fwd_rise) run_nxt = TCD_RUN_FWD;
            else if (rev_rise) run_nxt = TCD_RUN_REV;
            else run_nxt = run3_r;
         end
         TCD_THREE_WIRE_2: begin
            if (!f_3w) run_nxt = TCD_STOPPED;
            else if (fwd_rise || run3_r != TCD_STOPPED)
               run_nxt = f_rev ? TCD_RUN_REV : TCD_RUN_FWD;
         end
         default: run_nxt = TCD_STOPPED;
      endcase
      if (f_fstop || f_estop) run_nxt = TCD_STOPPED;
   end

   wire [15:0] preset = step_presets_in[step_idx*16 +: 16];
   wire [31:0] scaled = preset * max_frequency_in;
   wire [31:0] scaled_q = scaled / 32'(`TCD_FULL_SCALE);
   wire pid2  = (pid_gain_switch_condition_in == `TCD_PID_SW_TERM) &&
                fn_act[`TCD_FN_PID_SW];
   wire cmd_ok = cmd_source_terminal_in;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         fwd_d_r        <= 1'b0;
         rev_d_r        <= 1'b0;
         uf1_d_r        <= 1'b0;
         uf2_d_r        <= 1'b0;
         run3_r         <= TCD_STOPPED;
         cmd_out        <= '0;
         sel_out        <= '0;
         step_freq_out  <= 16'h0000;
         main_freq_out  <= 16'h0000;
         aux_freq_out   <= 16'h0000;
         fault_out      <= 1'b0;
         fault_code_out <= 8'h00;
      end else if (ce_in) begin
         fwd_d_r <= f_fwd;
         rev_d_r <= f_rev;
         uf1_d_r <= f_uf1;
         uf2_d_r <= f_uf2;
         run3_r  <= run_nxt;
         cmd_out.run           <= cmd_ok && (run_nxt != TCD_STOPPED);
         cmd_out.reverse       <= (run_nxt == TCD_RUN_REV);
         cmd_out.estop         <= f_estop;
         cmd_out.forced_stop   <= f_fstop;
         cmd_out.dc_brake      <= fn_act[`TCD_FN_DCBRAKE];
         cmd_out.runtime_clear <= fn_act[`TCD_FN_RT_CLEAR];
         sel_out.step_index    <= step_idx;
         sel_out.ramp_set      <= f_fstop ? `TCD_RAMP_SET4 : ramp_sel;
         sel_out.motor_set2    <= fn_act[`TCD_FN_MOTOR0] &&
                                  !fn_act[`TCD_FN_MOTOR1];
         sel_out.pid_gain_set2 <= pid2;
         sel_out.torque_mode   <= speed_torque_mode_select_in ^
                                  fn_act[`TCD_FN_SPD_TRQ];
         sel_out.main_use_preset <= fn_act[`TCD_FN_SRCX_PRESET];
         sel_out.aux_use_preset  <= fn_act[`TCD_FN_SRCY_PRESET];
         step_freq_out <= scaled_q[15:0];
         main_freq_out <= fn_act[`TCD_FN_SRCX_PRESET] ?
                          preset_frequency_in : main_source_in;
         aux_freq_out  <= fn_act[`TCD_FN_SRCY_PRESET] ?
                          preset_frequency_in : aux_source_in;
         // Fault 1 wins when both rise together; the fault 2 code is then not reported.
         fault_out <= (f_uf1 && !uf1_d_r) || (f_uf2 && !uf2_d_r);
         if (f_uf1 && !uf1_d_r) fault_code_out <= `TCD_FAULT_USER1;
         else if (f_uf2 && !uf2_d_r) fault_code_out <= `TCD_FAULT_USER2;
      end
   end

   sequence s_start3;
      mode == TCD_THREE_WIRE_1 && f_3w && fwd_rise && !f_fstop && !f_estop && ce_in;
   endsequence
   AST_THREE_WIRE_START: assert property (@(posedge clk_in) disable iff (rst_in)
      s_start3 |=> run3_r == TCD_RUN_FWD)
      else $error("Three-wire forward edge did not start run.");
   AST_THREE_WIRE_STOP: assert property (@(posedge clk_in) disable iff (rst_in)
      mode == TCD_THREE_WIRE_1 && !f_3w && ce_in |=> !cmd_out.run)
      else $error("Run continued with three-wire input open.");
   AST_FORCED_STOP_RAMP: assert property (@(posedge clk_in) disable iff (rst_in)
      f_fstop && ce_in |=> !cmd_out.run && sel_out.ramp_set == 2'h3)
      else $error("Forced stop did not use ramp set four.");
   AST_TWO_WIRE_FWD: assert property (@(posedge clk_in) disable iff (rst_in)
      mode == TCD_TWO_WIRE_1 && f_fwd && !f_rev && !f_fstop && !f_estop && cmd_ok && ce_in
      |=> cmd_out.run && !cmd_out.reverse)
      else $error("Two-wire forward level not honoured.");
   AST_STEP_INDEX: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in |=> sel_out.step_index == $past(step_idx))
      else $error("Step index mismatch.");
   AST_ESTOP: assert property (@(posedge clk_in) disable iff (rst_in)
      f_estop && ce_in |=> cmd_out.estop && !cmd_out.run)
      else $error("Emergency stop not applied.");
   AST_FAULT_CODE: assert property (@(posedge clk_in) disable iff (rst_in)
      f_uf1 && !uf1_d_r && ce_in |=> fault_out && fault_code_out == 8'h1b)
      else $error("User fault one code missing.");
   AST_MAIN_PRESET: assert property (@(posedge clk_in) disable iff (rst_in)
      fn_act[`TCD_FN_SRCX_PRESET] && ce_in |=> main_freq_out == $past(preset_frequency_in))
      else $error("Primary source not replaced by preset.");
endmodule // tcd_decoder
`default_nettype wire

// ---- tcd_filter.sv ----
// Purpose: One terminal synchroniser and stability filter.
// Assumes: Shared millisecond tick from the parent.
// Notes:   Three flops; a change counts when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module tcd_filter (
   input  wire logic       clk_in,     // Clock
   input  wire logic       rst_in,     // Synchronous reset
   input  wire logic       ce_in,      // Clock enable
   input  wire logic       tick_in,    // Millisecond tick
   input  wire logic [9:0] filt_ms_in, // Filter time in ms
   input  wire logic       pin_in,     // Raw terminal
   output logic            level_out   // Filtered level
);
   logic [2:0] sync_r;
   logic [9:0] cnt_r;
   logic       level_r;
   wire        agree   = (sync_r[1] == sync_r[2]);
   wire        differs = agree && (sync_r[2] != level_r);
   wire        done    = (cnt_r >= filt_ms_in);
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sync_r  <= 3'h0;
         cnt_r   <= 10'h000;
         level_r <= 1'b0;
      end else if (ce_in) begin
         sync_r <= {sync_r[1:0], pin_in};
         if (!differs) begin
            cnt_r <= 10'h000;
         end else if (done) begin
            level_r <= sync_r[2];
            cnt_r   <= 10'h000;
         end else if (tick_in) begin
            cnt_r <= cnt_r + 10'h001;
         end
      end
   end
   assign level_out = level_r;
endmodule // tcd_filter
`default_nettype wire

// ---- tcd_pkg.sv ----
// Purpose: Types for the terminal command decoder.
// Assumes: Included constants header.
// Notes:   None.
package tcd_pkg;
   typedef enum logic [1:0] {
      TCD_TWO_WIRE_1   = 2'b00,
      TCD_TWO_WIRE_2   = 2'b01,
      TCD_THREE_WIRE_1 = 2'b10,
      TCD_THREE_WIRE_2 = 2'b11
   } tcd_mode_e;
   typedef enum logic [1:0] {
      TCD_STOPPED = 2'b00,
      TCD_RUN_FWD = 2'b01,
      TCD_RUN_REV = 2'b10
   } tcd_run_e;
   typedef struct packed {
      logic       run;
      logic       reverse;
      logic       estop;
      logic       forced_stop;
      logic       dc_brake;
      logic       runtime_clear;
   } tcd_cmd_s;
   typedef struct packed {
      logic [3:0] step_index;
      logic [1:0] ramp_set;
      logic       motor_set2;
      logic       pid_gain_set2;
      logic       torque_mode;
      logic       main_use_preset;
      logic       aux_use_preset;
   } tcd_sel_s;
   typedef logic [5:0] tcd_fn_t;
endpackage

// ---- tcd_regs.svh ----
// Purpose: Constants for the terminal command decoder.
// Assumes: 125 MHz clock, 1 ms filter tick.
// Notes:   Filter time is given in milliseconds, 0 to 1023.
`ifndef TCD_REGS_SVH
`define TCD_REGS_SVH
`define TCD_NUM_TERM        10
`define TCD_CLK_MHZ         125
`define TCD_TICK_US         1000
`define TCD_TICK_CYCLES     (`TCD_TICK_US * `TCD_CLK_MHZ)
`define TCD_FILT_MS_RST     10'h00a
`define TCD_MODE_RST        2'h0
`define TCD_FN_FWD          6'h01
`define TCD_FN_REV          6'h02
`define TCD_FN_3WIRE        6'h03
`define TCD_FN_STEP0        6'h0c
`define TCD_FN_STEP1        6'h0d
`define TCD_FN_STEP2        6'h0e
`define TCD_FN_STEP3        6'h0f
`define TCD_FN_RAMP0        6'h10
`define TCD_FN_RAMP1        6'h11
`define TCD_FN_SRCX_PRESET  6'h27
`define TCD_FN_SRCY_PRESET  6'h28
`define TCD_FN_MOTOR0       6'h29
`define TCD_FN_MOTOR1       6'h2a
`define TCD_FN_PID_SW       6'h2b
`define TCD_FN_UFAULT1      6'h2c
`define TCD_FN_UFAULT2      6'h2d
`define TCD_FN_SPD_TRQ      6'h2e
`define TCD_FN_ESTOP        6'h2f
`define TCD_FN_FSTOP        6'h30
`define TCD_FN_DCBRAKE      6'h31
`define TCD_FN_RT_CLEAR     6'h32
`define TCD_FAULT_USER1     8'h1b
`define TCD_FAULT_USER2     8'h1c
`define TCD_PID_SW_TERM     2'h1
`define TCD_RAMP_SET4       2'h3
`define TCD_FULL_SCALE      16'h03e8
`endif

// ---- tcd_switch_model.sv ----
// Purpose: Switches and buttons that drive the decoder terminals.
// Assumes: The bench sets the wanted contact states just after an edge.
// Notes:   Contacts take effect one edge later, as a slow panel would.
`timescale 1ns/1ps
`default_nettype none
module tcd_switch_model (
   input  wire logic       clk_in,      // Clock
   input  wire logic [9:0] press_in,    // Wanted contact states
   output var  logic [9:0] terminal_out // Terminal levels
);
   initial terminal_out = 10'h000;
   // The bench closes terminal three before a start edge and opens it to stop.
   always @(posedge clk_in) begin
      terminal_out <= press_in;
   end
endmodule // tcd_switch_model
`default_nettype wire

// ---- terminal_command_decoder_tb.sv ----
// Purpose: Self-checking bench for the terminal command decoder.
// Assumes: Filter time 0 except in the filter scenario.
// Notes:   Terminal 9 takes the single-function codes in turn.
`timescale 1ns/1ps
`default_nettype none
module terminal_command_decoder_tb;
   import tcd_pkg::*;
   logic         clk_in = 1'b0;
   logic         rst_in = 1'b1;
   logic [9:0]   press  = 10'h000;
   logic [9:0]   filt   = 10'h000;
   logic [1:0]   mode   = 2'h0;
   logic         src    = 1'b1;
   logic         stm    = 1'b0;
   logic         ce     = 1'b1;
   logic [59:0]  fn;
   logic [255:0] presets;
   wire  [9:0]   term;
   tcd_cmd_s     cmd;
   tcd_sel_s     sel;
   logic [15:0]  stepf;
   logic [15:0]  mainf;
   logic [15:0]  auxf;
   logic         flt;
   logic [7:0]   fcode;
   logic [9:0]   lv;
   int n_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   int pulses = 0;

   always #4 clk_in = ~clk_in;

   tcd_switch_model i_tcd_switch_model (.clk_in(clk_in), .press_in(press), .terminal_out(term));

   tcd_decoder i_tcd_decoder (
      .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .terminal_in(term),
      .term_fn_in(fn), .input_filter_time_in(filt), .terminal_command_mode_in(mode),
      .cmd_source_terminal_in(src), .pid_gain_switch_condition_in(2'h1),
      .speed_torque_mode_select_in(stm), .max_frequency_in(16'h1388),
      .preset_frequency_in(16'h0777), .main_source_in(16'h0123),
      .aux_source_in(16'h0456), .step_presets_in(presets), .cmd_out(cmd),
      .sel_out(sel), .step_freq_out(stepf), .main_freq_out(mainf),
      .aux_freq_out(auxf), .fault_out(flt), .fault_code_out(fcode), .filtered_out(lv));

   task automatic end_of_test();
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Fault pulses are counted so that a stuck pulse shows as a count above one.
   always @(posedge clk_in) begin
      cyc++;
      if (flt === 1'b1) pulses++;
      if (cyc == 5000) begin
         n_errors++;
         end_of_test();
      end
   end

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic put(input logic [9:0] p);
      int k;
      @(posedge clk_in);
      #1;
      press = p;
      k = 0;
      while (lv !== p && k < 60) begin
         @(posedge clk_in);
         k++;
      end
      repeat (3) @(posedge clk_in);
      #1;
   endtask

   task automatic go(input logic [9:0] p, input logic r, input logic v);
      put(p);
      chk("run", 16'(cmd.run), 16'(r));
      if (r) chk("reverse", 16'(cmd.reverse), 16'(v));
   endtask

   function automatic logic [15:0] probe(input logic [5:0] c);
      case (c)
         6'h27: return mainf;
         6'h28: return auxf;
         6'h29, 6'h2a: return 16'(sel.motor_set2);
         6'h2b: return 16'(sel.pid_gain_set2);
         6'h2c, 6'h2d: return {8'(pulses), fcode};
         6'h2e: return 16'(sel.torque_mode);
         6'h2f: return 16'({cmd.estop, cmd.run});
         6'h30: return 16'({cmd.forced_stop, cmd.run, sel.ramp_set});
         6'h31: return 16'(cmd.dc_brake);
         default: return 16'(cmd.runtime_clear);
      endcase
   endfunction

   // Forward run is held on terminal 0 so that stop functions have a run to cut.
   task automatic t_fn(input logic [5:0] c, input logic [15:0] on_v, input logic [15:0] off_v);
      mode = 2'h0;
      fn[59:54] = c;
      pulses = 0;
      put(10'h201);
      chk("function on", probe(c), on_v);
      put(10'h001);
      chk("function off", probe(c), off_v);
      put(10'h000);
   endtask

   task automatic t_step();
      for (int i = 0; i < 16; i++) begin
         put(10'(i) << 3);
         chk("step_index", 16'(sel.step_index), 16'(i));
         chk("step_freq", stepf, 16'((100 * i * 5000) / 1000));
      end
      for (int j = 0; j < 4; j++) begin
         put(10'(j) << 7);
         chk("ramp_set", 16'(sel.ramp_set), 16'(j));
      end
   endtask

   task automatic t_filt();
      logic seen;
      seen = 1'b0;
      filt = 10'h001;
      fn[59:54] = 6'h32;
      press = 10'h200;
      repeat (30) @(posedge clk_in);
      #1;
      press = 10'h000;
      repeat (400) begin
         @(posedge clk_in);
         seen = seen | lv[9] | cmd.runtime_clear;
      end
      chk("short pulse", 16'(seen), 16'h0000);
      filt = 10'h000;
   endtask

   // With the clock enable low a held forward contact must not reach the outputs.
   task automatic t_ce();
      ce = 1'b0;
      press = 10'h001;
      repeat (20) @(posedge clk_in);
      #1;
      chk("frozen", 16'({lv[0], cmd.run}), 16'h0000);
      press = 10'h000;
      repeat (5) @(posedge clk_in);
      #1;
      ce = 1'b1;
   endtask

   initial begin
      fn = {6'h00, 6'h11, 6'h10, 6'h0f, 6'h0e, 6'h0d, 6'h0c, 6'h03, 6'h02, 6'h01};
      for (int i = 0; i < 16; i++) begin
         presets[16*i +: 16] = 16'(100 * i);
      end
      repeat (2) @(posedge clk_in);
      #1;
      rst_in = 1'b0;
      chk("cmd reset", 16'(cmd), 16'h0000);
      chk("sel reset", 16'(sel), 16'h0000);
      t_step();
      go(10'h001, 1'b1, 1'b0);
      go(10'h002, 1'b1, 1'b1);
      go(10'h003, 1'b0, 1'b0);
      go(10'h000, 1'b0, 1'b0);
      mode = 2'h1;
      go(10'h001, 1'b1, 1'b0);
      go(10'h003, 1'b1, 1'b1);
      go(10'h002, 1'b0, 1'b0);
      go(10'h000, 1'b0, 1'b0);
      mode = 2'h2;
      go(10'h001, 1'b0, 1'b0);
      go(10'h005, 1'b0, 1'b0);
      go(10'h004, 1'b0, 1'b0);
      go(10'h005, 1'b1, 1'b0);
      go(10'h004, 1'b1, 1'b0);
      go(10'h006, 1'b1, 1'b1);
      go(10'h004, 1'b1, 1'b1);
      go(10'h000, 1'b0, 1'b0);
      go(10'h001, 1'b0, 1'b0);
      mode = 2'h3;
      go(10'h004, 1'b0, 1'b0);
      go(10'h005, 1'b1, 1'b0);
      go(10'h006, 1'b1, 1'b1);
      go(10'h000, 1'b0, 1'b0);
      src = 1'b0;
      mode = 2'h0;
      go(10'h001, 1'b0, 1'b0);
      src = 1'b1;
      put(10'h000);
      t_fn(6'h27, 16'h0777, 16'h0123);
      t_fn(6'h28, 16'h0777, 16'h0456);
      t_fn(6'h29, 16'h0001, 16'h0000);
      t_fn(6'h2a, 16'h0000, 16'h0000);
      t_fn(6'h2b, 16'h0001, 16'h0000);
      t_fn(6'h2c, 16'h011b, 16'h011b);
      t_fn(6'h2d, 16'h011c, 16'h011c);
      t_fn(6'h2e, 16'h0001, 16'h0000);
      stm = 1'b1;
      t_fn(6'h2e, 16'h0000, 16'h0001);
      t_fn(6'h2f, 16'h0002, 16'h0001);
      t_fn(6'h30, 16'h000b, 16'h0004);
      t_fn(6'h31, 16'h0001, 16'h0000);
      t_fn(6'h32, 16'h0001, 16'h0000);
      t_filt();
      t_ce();
      end_of_test();
   end
endmodule // terminal_command_decoder_tb
`default_nettype wire
